// ===== rtl/ocdc_consts.vh
// Purpose : Constants for the debug control block.
// Assumes : 20 MHz system clock, 32-bit AXI4-Lite register bus.
// Notes   : Offsets are byte addresses of aligned words.
`ifndef OCDC_CONSTS_VH
`define OCDC_CONSTS_VH

// ==========
// Register offsets
// ==========
`define OCDC_OFF_CTRL     4'h0
`define OCDC_OFF_STAT     4'h4
`define OCDC_OFF_CNTR     4'h8
`define OCDC_OFF_IRQ_ST   4'hc

// ==========
// Control register fields
// ==========
`define OCDC_CTRL_DBG     0
`define OCDC_CTRL_MODE_LO 1
`define OCDC_CTRL_MODE_HI 2

// ==========
// Counter uses
// ==========
`define OCDC_USE_NONE     2'h0
`define OCDC_USE_CYCLES   2'h1
`define OCDC_USE_DOWN     2'h2
`define OCDC_USE_PCMATCH  2'h3

// ==========
// Interrupt status bits
// ==========
`define OCDC_IRQ_ENTRY    0
`define OCDC_IRQ_RXBYTE   1
`define OCDC_IRQ_FRAMERR  2
`define OCDC_IRQ_REFUSED  3
`define OCDC_IRQ_W        4

// ==========
// Debug link timing
// ==========
`define OCDC_CLK_HZ       20000000
`define OCDC_BAUD         115200
`define OCDC_BIT_CYC      (`OCDC_CLK_HZ / `OCDC_BAUD)
`define OCDC_CMD_RESTRICT 8'h80
`define OCDC_CMD_READOUT  8'h40

`endif

// ===== rtl/ocdc_uart.v
// Purpose : Character framing on the single debug wire, receive and send.
// Assumes : Line already synchronised; tx_go only while tx_busy is low.
// Notes   : One start bit, eight data bits LSB first, one stop bit.
`timescale 1ns/1ps
`default_nettype none

module ocdc_uart #(
    parameter integer BIT_CYC = 173
) (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       ce,
    input  wire       rx_line,
    input  wire       tx_go,
    input  wire [7:0] tx_byte,
    output reg        tx_busy,
    output reg        tx_drive_low,
    output reg        rx_valid,
    output reg  [7:0] rx_byte,
    output reg        rx_frame_err
);

    reg [15:0] rx_cnt_reg;
    reg [3:0]  rx_bit_reg;
    reg        rx_act_reg;
    reg        rx_prev_reg;
    reg [7:0]  rx_sh_reg;
    reg [15:0] tx_cnt_reg;
    reg [3:0]  tx_bit_reg;
    reg [9:0]  tx_sh_reg;

    // ==========
    // Receiver
    // ==========
    // A falling edge starts a frame; each bit is sampled half a bit in.
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 4'h0;
            rx_act_reg   <= 1'b0;
            rx_prev_reg  <= 1'b1;
            rx_sh_reg    <= 8'h00;
            rx_valid     <= 1'b0;
            rx_byte      <= 8'h00;
            rx_frame_err <= 1'b0;
        end else if (ce) begin
            rx_prev_reg  <= rx_line;
            rx_valid     <= 1'b0;
            rx_frame_err <= 1'b0;
            if (!rx_act_reg) begin
                if (rx_prev_reg && !rx_line) begin
                    rx_act_reg <= 1'b1;
                    rx_bit_reg <= 4'h0;
                    rx_cnt_reg <= BIT_CYC[15:0] >> 1;
                end
            end else if (rx_cnt_reg != 16'h0000) begin
                rx_cnt_reg <= rx_cnt_reg - 16'h0001;
            end else begin
                rx_cnt_reg <= BIT_CYC[15:0] - 16'h0001;
                rx_bit_reg <= rx_bit_reg + 4'h1;
                if (rx_bit_reg == 4'h0) begin
                    // A start bit that is high again was a glitch.
                    if (rx_line) rx_act_reg <= 1'b0;
                end else if (rx_bit_reg < 4'h9) begin
                    rx_sh_reg <= {rx_line, rx_sh_reg[7:1]};
                end else begin
                    rx_act_reg <= 1'b0;
                    if (rx_line) begin
                        rx_valid <= 1'b1;
                        rx_byte  <= rx_sh_reg;
                    end else begin
                        rx_frame_err <= 1'b1;
                    end
                end
            end
        end
    end

    // ==========
    // Transmitter
    // ==========
    // The frame is shifted out LSB first behind a low start bit.
    always @(posedge aclk) begin
        if (!aresetn) begin
            tx_cnt_reg   <= 16'h0000;
            tx_bit_reg   <= 4'h0;
            tx_sh_reg    <= 10'h3ff;
            tx_busy      <= 1'b0;
            tx_drive_low <= 1'b0;
        end else if (ce) begin
            if (!tx_busy) begin
                tx_drive_low <= 1'b0;
                if (tx_go) begin
                    tx_sh_reg    <= {1'b1, tx_byte, 1'b0};
                    tx_busy      <= 1'b1;
                    tx_bit_reg   <= 4'h0;
                    tx_cnt_reg   <= BIT_CYC[15:0] - 16'h0001;
                    tx_drive_low <= 1'b1;
                end
            end else if (tx_cnt_reg != 16'h0000) begin
                tx_cnt_reg <= tx_cnt_reg - 16'h0001;
            end else begin
                tx_cnt_reg <= BIT_CYC[15:0] - 16'h0001;
                tx_bit_reg <= tx_bit_reg + 4'h1;
                tx_sh_reg  <= {1'b1, tx_sh_reg[9:1]};
                if (tx_bit_reg == 4'h9) begin
                    tx_busy      <= 1'b0;
                    tx_drive_low <= 1'b0;
                end else begin
                    tx_drive_low <= ~tx_sh_reg[1];
                end
            end
        end
    end

endmodule // ocdc_uart

`default_nettype wire

// ===== rtl/ocdc_top.v
// Purpose : Debug state control, multipurpose counter and debug link front.
// Assumes : AXI4-Lite master of the system; pins are asynchronous.
// Notes   : Command decoding beyond the permission gate lives in firmware.
//
// What this block does
// - In debug state the core fetch is held; only directed instructions run.
// - System clock and enabled peripherals keep running in debug, except deep sleep.
// - Entering debug state forces the core out of idle halt mode.
// - An enabled watchdog is refreshed every cycle while the debug state lasts.
// - Enter debug on request bit, breakpoint, PC match or countdown to zero.
// - Debug pin low at reset release enters debug state.
// - Leave debug on request bit cleared, power-on, brownout or reset pin.
// - Debug pin low in deep sleep requests full system reset.
// - Characters are start bit, eight data bits LSB first, stop bit.
// - Cycle use counts clocks outside debug, saturating at all ones.
// - Cycle use clears the counter when the request bit is written clear.
// - Counter breaks by counting down to zero or matching the PC.
// - Commands reuse the counter as byte count and CRC residue.
// - Outside debug only a command subset is accepted; inside, all but readouts under read protect.
// - Read protect disables memory readout commands.
`timescale 1ns/1ps
`default_nettype none
`include "ocdc_consts.vh"

module ocdc_top #(
    parameter integer BIT_CYC = `OCDC_BIT_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        ce,
    // AXI4-Lite slave.
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Debug link pin, open drain.
    input  wire        debug_link_pin_in,
    output wire        debug_link_pin_out,
    output wire        debug_link_pin_oe,
    // Core and system side.
    input  wire        breakpoint_instruction,
    input  wire [15:0] core_pc,
    input  wire        core_halted,
    input  wire        deep_sleep,
    input  wire        wdt_enabled,
    input  wire        por_event,
    input  wire        brownout_event,
    input  wire        reset_pin_n,
    input  wire        read_protect_option,
    input  wire        cmd_strobe,
    input  wire [7:0]  cmd_code,
    input  wire        cnt_load,
    input  wire [15:0] cnt_load_value,
    input  wire        cnt_dec,
    output reg         fetch_hold,
    output reg         halt_exit,
    output reg         wdt_refresh,
    output reg         sys_reset_req,
    output reg         clock_run,
    output reg         cmd_accept,
    output reg         cmd_refuse,
    output reg  [15:0] debug_multipurpose_counter,
    output reg         irq
);

    // ==========
    // Pin synchronisers
    // ==========
    reg [1:0] pin_sync_reg;
    reg [1:0] rst_sync_reg;
    wire      pin_s = pin_sync_reg[1];
    wire      rst_pin_n_s = rst_sync_reg[1];

    // They keep sampling through reset, so the strap level is settled at release.
    always @(posedge aclk) begin
        if (ce) begin
            pin_sync_reg <= {pin_sync_reg[0], debug_link_pin_in};
            rst_sync_reg <= {rst_sync_reg[0], reset_pin_n};
        end
    end

    // ==========
    // Debug link framing
    // ==========
    wire       tx_busy;
    wire       tx_low;
    wire       rx_valid;
    wire [7:0] rx_byte;
    wire       rx_ferr;
    reg        tx_go_reg;
    reg  [7:0] tx_byte_reg;

    ocdc_uart #(
        .BIT_CYC (BIT_CYC)
    ) u_uart (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .ce           (ce),
        .rx_line      (pin_s),
        .tx_go        (tx_go_reg),
        .tx_byte      (tx_byte_reg),
        .tx_busy      (tx_busy),
        .tx_drive_low (tx_low),
        .rx_valid     (rx_valid),
        .rx_byte      (rx_byte),
        .rx_frame_err (rx_ferr)
    );

    // Open drain: only ever pull low, the line idles high by pull-up.
    assign debug_link_pin_out = 1'b0;
    assign debug_link_pin_oe  = tx_low;

    // ==========
    // Register file state
    // ==========
    reg        debug_state_request_bit;
    reg [1:0]  cnt_use_reg;
    reg [3:0]  irq_mask_reg;
    reg [3:0]  irq_stat_reg;
    reg        first_cycle_reg;
    reg        cnt_break;
    reg        enter_evt;
    reg        leave_evt;
    reg        ext_reset;
    reg        sw_set;
    reg        sw_clr;
    reg        stat_read;
    reg        readout;

    // ==========
    // Entry and exit of the debug state
    // ==========
    // Counter breakpoints fire only while running, never inside debug.
    always @* begin
        cnt_break = 1'b0;
        if (!debug_state_request_bit) begin
            if (cnt_use_reg == `OCDC_USE_DOWN && cnt_dec &&
                debug_multipurpose_counter == 16'h0001)
                cnt_break = 1'b1;
            if (cnt_use_reg == `OCDC_USE_PCMATCH &&
                core_pc == debug_multipurpose_counter)
                cnt_break = 1'b1;
        end
        ext_reset = por_event | brownout_event | ~rst_pin_n_s;
        enter_evt = breakpoint_instruction | cnt_break | sw_set;
        leave_evt = sw_clr & ~enter_evt;
    end

    // The strap is caught by the first enabled edge after reset release.
    always @(posedge aclk) begin
        if (!aresetn) begin
            debug_state_request_bit <= 1'b0;
            first_cycle_reg         <= 1'b1;
            sys_reset_req           <= 1'b0;
        end else if (ce) begin
            first_cycle_reg <= 1'b0;
            sys_reset_req   <= deep_sleep & ~pin_s;
            if (ext_reset || (deep_sleep && !pin_s))
                debug_state_request_bit <= 1'b0;
            else if (first_cycle_reg && !pin_s)
                debug_state_request_bit <= 1'b1;
            else if (enter_evt)
                debug_state_request_bit <= 1'b1;
            else if (leave_evt)
                debug_state_request_bit <= 1'b0;
        end
    end

    // Core side effects of the debug state.
    always @(posedge aclk) begin
        if (!aresetn) begin
            fetch_hold  <= 1'b0;
            halt_exit   <= 1'b0;
            wdt_refresh <= 1'b0;
            clock_run   <= 1'b1;
        end else if (ce) begin
            fetch_hold  <= debug_state_request_bit;
            halt_exit   <= debug_state_request_bit & core_halted;
            wdt_refresh <= debug_state_request_bit & wdt_enabled;
            clock_run   <= ~deep_sleep;
        end
    end

    // ==========
    // Multipurpose counter
    // ==========
    // Command loads win over counting because the host may reuse it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            debug_multipurpose_counter <= 16'h0000;
        end else if (ce) begin
            if (cnt_load)
                debug_multipurpose_counter <= cnt_load_value;
            else if (cnt_use_reg == `OCDC_USE_CYCLES && leave_evt)
                debug_multipurpose_counter <= 16'h0000;
            else if (cnt_use_reg == `OCDC_USE_CYCLES && !debug_state_request_bit &&
                     debug_multipurpose_counter != 16'hffff)
                debug_multipurpose_counter <= debug_multipurpose_counter + 16'h0001;
            else if (cnt_dec && debug_multipurpose_counter != 16'h0000 &&
                     (debug_state_request_bit || cnt_use_reg == `OCDC_USE_DOWN))
                debug_multipurpose_counter <= debug_multipurpose_counter - 16'h0001;
        end
    end

    // ==========
    // Command permission gate
    // ==========
    always @* begin
        readout = (cmd_code & `OCDC_CMD_READOUT) != 8'h00;
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_accept <= 1'b0;
            cmd_refuse <= 1'b0;
        end else if (ce) begin
            cmd_accept <= 1'b0;
            cmd_refuse <= 1'b0;
            if (cmd_strobe) begin
                if (!debug_state_request_bit && (cmd_code & `OCDC_CMD_RESTRICT) != 8'h00)
                    cmd_refuse <= 1'b1;
                else if (read_protect_option && readout)
                    cmd_refuse <= 1'b1;
                else
                    cmd_accept <= 1'b1;
            end
        end
    end

    // ==========
    // AXI4-Lite slave
    // ==========
    // Write address and data are taken together once both are offered.
    wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire rd_take = s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_awready = wr_take & ce;
    assign s_axi_wready  = wr_take & ce;
    assign s_axi_arready = rd_take & ce;

    always @* begin
        sw_set    = 1'b0;
        sw_clr    = 1'b0;
        stat_read = rd_take & ce & (s_axi_araddr == `OCDC_OFF_IRQ_ST);
        if (wr_take && ce && s_axi_awaddr == `OCDC_OFF_CTRL && s_axi_wstrb[0]) begin
            sw_set = s_axi_wdata[`OCDC_CTRL_DBG];
            sw_clr = ~s_axi_wdata[`OCDC_CTRL_DBG];
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            cnt_use_reg  <= `OCDC_USE_NONE;
            irq_mask_reg <= 4'h0;
            tx_go_reg    <= 1'b0;
            tx_byte_reg  <= 8'h00;
        end else if (ce) begin
            tx_go_reg <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (s_axi_awaddr)
                    `OCDC_OFF_CTRL: begin
                        if (s_axi_wstrb[0])
                            cnt_use_reg <= s_axi_wdata[`OCDC_CTRL_MODE_HI:`OCDC_CTRL_MODE_LO];
                    end
                    `OCDC_OFF_STAT: begin
                        if (s_axi_wstrb[0] && !tx_busy) begin
                            tx_byte_reg <= s_axi_wdata[7:0];
                            tx_go_reg   <= 1'b1;
                        end
                    end
                    `OCDC_OFF_CNTR: begin
                        if (s_axi_wstrb[0])
                            irq_mask_reg <= s_axi_wdata[3:0];
                    end
                    `OCDC_OFF_IRQ_ST: begin
                    end
                    default: s_axi_bresp <= 2'b10;
                endcase
            end
        end
    end

    // Reads answer one cycle after the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    `OCDC_OFF_CTRL:   s_axi_rdata <= {29'h0, cnt_use_reg,
                                                      debug_state_request_bit};
                    `OCDC_OFF_STAT:   s_axi_rdata <= {16'h0, irq_mask_reg, tx_busy,
                                                      read_protect_option, 2'h0, rx_byte};
                    `OCDC_OFF_CNTR:   s_axi_rdata <= {16'h0, debug_multipurpose_counter};
                    `OCDC_OFF_IRQ_ST: s_axi_rdata <= {28'h0, irq_stat_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end

    // ==========
    // Interrupts
    // ==========
    // A read clears the sticky bits, but an event in that same cycle stays set.
    wire [3:0] irq_evt = {cmd_refuse, rx_ferr, rx_valid,
                          enter_evt & ~debug_state_request_bit};

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= 4'h0;
            irq          <= 1'b0;
        end else if (ce) begin
            irq_stat_reg <= (stat_read ? 4'h0 : irq_stat_reg) | irq_evt;
            irq          <= |(((stat_read ? 4'h0 : irq_stat_reg) | irq_evt) & irq_mask_reg);
        end
    end

endmodule // ocdc_top

`default_nettype wire

// ===== test/ocdc_top_assertions.sv
// Purpose: Port checks of the debug control block.
// Assumes: One clock, synchronous active-low reset, ce held high.
// Notes: Async pins pass two sync flops before they act.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module ocdc_top_checker (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       deep_sleep,
    input wire logic       wdt_enabled,
    input wire logic       breakpoint_instruction,
    input wire logic       por_event,
    input wire logic       brownout_event,
    input wire logic       reset_pin_n,
    input wire logic       read_protect_option,
    input wire logic       cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic       debug_link_pin_in,
    input wire logic       fetch_hold,
    input wire logic       wdt_refresh,
    input wire logic       sys_reset_req,
    input wire logic       clock_run,
    input wire logic       cmd_accept,
    input wire logic       cmd_refuse
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Watchdog kept alive once debug and enable have both lasted a cycle.
    property p_wdt;
        fetch_hold && $past(fetch_hold) && wdt_enabled && $past(wdt_enabled) |-> wdt_refresh;
    endproperty
    a_wdt: assert property (p_wdt)
        else $error("watchdog not refreshed");
    property p_clk;
        $stable(deep_sleep) |-> clock_run == !deep_sleep;
    endproperty
    a_clk: assert property (p_clk)
        else $error("clock run wrong");
    property p_brk;
        breakpoint_instruction && !deep_sleep && !por_event && !brownout_event && reset_pin_n
            && $past(reset_pin_n) && $past(reset_pin_n, 2) |-> ##2 fetch_hold;
    endproperty
    a_brk: assert property (p_brk)
        else $error("breakpoint missed");
    property p_exit;
        por_event || brownout_event |-> ##2 !fetch_hold;
    endproperty
    a_exit: assert property (p_exit)
        else $error("debug kept over reset");
    // Two sync flops, the state flop and the output flop need five low samples.
    property p_sleep;
        (deep_sleep && !debug_link_pin_in) [*5] |-> sys_reset_req && !fetch_hold;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("no reset from sleep");
    property p_restrict;
        cmd_strobe && cmd_code[7] |=> fetch_hold || (cmd_refuse && !cmd_accept);
    endproperty
    a_restrict: assert property (p_restrict)
        else $error("restricted command taken");
    property p_protect;
        cmd_strobe && cmd_code[6] && read_protect_option |=> cmd_refuse && !cmd_accept;
    endproperty
    a_protect: assert property (p_protect)
        else $error("readout taken");
    property p_accept;
        cmd_strobe && !read_protect_option |=> (cmd_accept && !cmd_refuse)
            || (!fetch_hold && $past(cmd_code[7]));
    endproperty
    a_accept: assert property (p_accept)
        else $error("command refused in debug");
endmodule // ocdc_top_checker
bind ocdc_top ocdc_top_checker ocdc_top_checker_inst (.*);
`default_nettype wire

// ===== test/ocdc_host_model.sv
// Purpose: Host debugger on the single debug wire.
// Assumes: Wire pulled high; a bit lasts BIT_CYC clocks.
// Notes: The receiver also hears the host's own frames.
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host model
module ocdc_host_model #(
    parameter int BIT_CYC = 8
) (
    input  wire logic aclk,
    input  wire logic line,
    output var  logic drive_low
);
    logic [7:0] got;
    int         got_n = 0;
    initial drive_low = 1'b0;
    // Releasing the wire for the stop bit lets the pull-up restore idle.
    task send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            drive_low <= !f[i];
            repeat (BIT_CYC) @(posedge aclk);
        end
    endtask
    // Start on a falling edge, then sample each bit mid-period.
    always begin
        @(negedge line);
        repeat (BIT_CYC / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge aclk);
            got[i] = line;
        end
        repeat (BIT_CYC) @(posedge aclk);
        got_n++;
    end
endmodule // ocdc_host_model
`default_nettype wire

// ===== test/ocdc_top_tb.sv
// Purpose: Self-checking bench of the debug control block.
// Assumes: Short bit period; host model on the wire.
// Notes: Mask polarity is checked only as a difference.
`timescale 1ns/1ps
`default_nettype none
module ocdc_top_tb;
    localparam int BC = 8;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 0, s_axi_rready = 0, core_halted = 0, deep_sleep = 0, wdt_enabled = 0;
    logic reset_pin_n = 1, read_protect_option = 0, cmd_strobe = 0, tlow = 0, x;
    logic [4:0] ev = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [7:0] cmd_code = 0;
    logic [15:0] core_pc = 0, cnt_load_value = 0, c0;
    logic [31:0] s_axi_wdata = 0, rdd, rn, lf = 32'h75d24a48;
    wire breakpoint_instruction, por_event, brownout_event, cnt_dec, cnt_load, hlow, irq;
    wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, halt_exit;
    wire debug_link_pin_oe, fetch_hold, wdt_refresh, sys_reset_req, clock_run, cmd_accept;
    wire cmd_refuse;
    wire [31:0] s_axi_rdata;
    wire [15:0] debug_multipurpose_counter;
    wire debug_link_pin_in = !(debug_link_pin_oe | hlow | tlow);
    int errors = 0, checks = 0, cyc = 0;
    assign {cnt_load, cnt_dec, brownout_event, por_event, breakpoint_instruction} = ev;
    // ==========
    // Clock, timeout and instances
    always #25 aclk = !aclk;
    always @(posedge aclk) if (++cyc == 20000) begin errors++; summarize(); end
    ocdc_top #(.BIT_CYC(BC)) ocdc_top_inst (.*, .ce(1'b1), .s_axi_wstrb(4'hf),
        .s_axi_bresp(), .s_axi_rresp(), .debug_link_pin_out());
    ocdc_host_model #(.BIT_CYC(BC)) ocdc_host_model_inst (.aclk, .line(debug_link_pin_in),
        .drive_low(hlow));
    task summarize;
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(string n, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end
    endtask
    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    // Commands pass unless restricted outside debug or a readout under protection.
    function automatic logic ok(logic [7:0] c, logic d, logic p);
        return !(c[7] && !d) && !(c[6] && p);
    endfunction
    task cy(int n); repeat (n) @(posedge aclk); endtask
    task pls(int i); @(posedge aclk); ev[i] <= 1; @(posedge aclk); ev <= 0; cy(2); endtask
    task wrr(logic [3:0] a, logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
        {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
    endtask
    task rdr(logic [3:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        rdd = s_axi_rdata;
        s_axi_rready <= 0;
    endtask
    task cmdq(int n);
        repeat (n) begin
            rn = rnd();
            @(posedge aclk);
            {cmd_code, read_protect_option, cmd_strobe} <= {rn[7:0], rn[8], 1'b1};
            @(posedge aclk);
            cmd_strobe <= 0;
            x = ok(rn[7:0], fetch_hold, rn[8]);
            @(posedge aclk);
            chk("accept", x, cmd_accept);
            chk("refuse", !x, cmd_refuse);
        end
    endtask
    // ==========
    // Main sequence
    initial begin
        cy(8);
        aresetn <= 1;
        cy(2);
        chk("dbg", 0, fetch_hold);
        wrr(0, 1);
        cy(1);
        chk("dbg", 1, fetch_hold);
        wrr(8, 0);
        cy(2);
        x = irq;
        wrr(8, 32'hf);
        cy(2);
        chk("irq", !x, irq);
        rdr(4'hc);
        chk("entry", 1, rdd[0]);
        cy(2);
        chk("irq", 0, irq);
        wdt_enabled <= 1;
        core_halted <= 1;
        cmdq(12);
        chk("wdt", 1, wdt_refresh);
        chk("halt", 1, halt_exit);
        pls(1);
        chk("dbg", 0, fetch_hold);
        cmdq(12);
        pls(0);
        chk("dbg", 1, fetch_hold);
        wrr(0, 3);
        wrr(0, 2);
        chk("clr", 0, debug_multipurpose_counter);
        c0 = debug_multipurpose_counter;
        cy(10);
        chk("cyc", c0 + 16'ha, debug_multipurpose_counter);
        pls(0);
        c0 = debug_multipurpose_counter;
        cy(5);
        chk("stop", c0, debug_multipurpose_counter);
        wrr(0, 2);
        cnt_load_value <= 16'hfff0;
        pls(4);
        cy(30);
        chk("sat", 16'hffff, debug_multipurpose_counter);
        wrr(0, 5);
        cnt_load_value <= 16'h0003;
        pls(4);
        chk("load", 3, debug_multipurpose_counter);
        wrr(0, 4);
        pls(3);
        pls(3);
        chk("dbg", 0, fetch_hold);
        pls(3);
        chk("dbg", 1, fetch_hold);
        rn = rnd();
        cnt_load_value <= rn[15:0] | 16'h1;
        pls(4);
        wrr(0, 6);
        cy(3);
        chk("dbg", 0, fetch_hold);
        core_pc <= cnt_load_value;
        cy(3);
        chk("dbg", 1, fetch_hold);
        c0 = 16'(ocdc_host_model_inst.got_n);
        wrr(4, {24'h0, rn[23:16]});
        while (ocdc_host_model_inst.got_n == c0) cy(1);
        chk("tx", rn[23:16], ocdc_host_model_inst.got);
        cy(BC);
        ocdc_host_model_inst.send(rn[31:24]);
        cy(2 * BC);
        rdr(4);
        chk("rx", rn[31:24], rdd[7:0]);
        deep_sleep <= 1;
        cy(2);
        chk("clk", 0, clock_run);
        tlow <= 1;
        cy(5);
        chk("srst", 1, sys_reset_req);
        deep_sleep <= 0;
        aresetn <= 0;
        cy(8);
        aresetn <= 1;
        cy(3);
        tlow <= 0;
        chk("dbg", 1, fetch_hold);
        summarize();
    end
endmodule // ocdc_top_tb
`default_nettype wire
